// [rtl/dsrf_consts.vh]
`ifndef DSRF_CONSTS_VH
`define DSRF_CONSTS_VH

// ****************************************
// command codes
// ****************************************
`define DSRF_CMD_INIT       4'h0
`define DSRF_CMD_STATUS     4'h1
`define DSRF_CMD_ACCEL      4'h2
`define DSRF_CMD_REQ_ID     4'h4
`define DSRF_CMD_CLEAR      4'h7
`define DSRF_CMD_NVM        4'h9
`define DSRF_CMD_FORMAT     4'hA
`define DSRF_CMD_REG_READ   4'hB
`define DSRF_CMD_ST_OFF     4'hC
`define DSRF_CMD_ST_ON      4'hD
`define DSRF_CMD_REV_INIT   4'hF

// ****************************************
// addresses and command data fields
// ****************************************
`define DSRF_GLOBAL_ADDR    4'h0
`define DSRF_BANK_INVALID   2'h3
`define DSRF_FMT_PATTERN    4'h6
`define DSRF_ID_TAIL        5'h04
`define DSRF_PRG_BIT        7
`define DSRF_BSW_BIT        6
`define DSRF_FMT_RW_BIT     7

// ****************************************
// software register map and reset values
// ****************************************
`define DSRF_REG_CFG_ONE    5'h00
`define DSRF_REG_CFG_TWO    5'h01
`define DSRF_REG_LOCK       5'h02
`define DSRF_REG_STATE      5'h03
`define DSRF_REG_USER_BASE  5'h10
`define DSRF_GROUND_LOSS_DETECT_ENABLE_BIT       0
`define DSRF_CFG_RESET      8'h00
`define DSRF_FMT_RESET      4'h0
`define DSRF_USER_RESET     8'h00

`endif

// [rtl/dsrf_responder.v]
// Our own choices: the placing of the registers and the strobed register port.
`timescale 1ns/10ps
`include "dsrf_consts.vh"

module dsrf_responder #(
  parameter [2:0] VERSION_ID = 3'h1  // arbitrary value
) (
  input  wire        CLOCK,
  input  wire        RST_N,
  input  wire        CMD_VALID,
  input  wire        CMD_CRC_OK,
  input  wire [3:0]  CMD_CODE,
  input  wire [3:0]  CMD_ADDR,
  input  wire [7:0]  CMD_DATA,
  input  wire [3:0]  PRESET_ADDR,
  input  wire        PRESET_VALID,
  input  wire        BUS_TEST_FAULT,
  input  wire        GROUND_FAULT,
  input  wire        HOLD_CAPACITOR_LOW,
  input  wire        OTP_PARITY_FAULT,
  input  wire        FUSE_THRESHOLD_FAULT,
  input  wire [9:0]  ACCEL_RESULT,
  input  wire [4:0]  REG_ADDR,
  input  wire [7:0]  REG_WDATA,
  input  wire        REG_WR,
  input  wire        REG_RD,
  output reg  [7:0]  REG_RDATA,
  output reg         RESP_VALID,
  output reg  [15:0] RESP_WORD,
  output reg  [3:0]  NODE_ADDRESS,
  output reg         BUS_SWITCH_CLOSED,
  output reg         SELFTEST_ACTIVE,
  output reg         OTP_PROGRAM_ENABLE
);

  // ****************************************
  // state
  // ****************************************
  // the node address, switch, self-test and program enable are top-level
  // outputs and so live directly in the output flip-flops; the fault inputs, the
  // acceleration result and echoed command fields go into a response live; the rest is held in the registers below.
  //
  // preset_pending_reg marks the first edge after reset release, on which
  // the preset address is copied in; address_preset_reg remembers whether a
  // preset existed, since that changes how an initialization is accepted.
  //
  // the format and user arrays are plain flip-flops indexed by field value;
  // the user array stands in for the customer otp area and is also visible
  // to software, so a test can preload it without otp programming.
  reg  [7:0]  device_config_one_reg;
  reg  [7:0]  device_config_two_reg;
  reg         attribute_lock_reg;
  reg         preset_pending_reg;
  reg         address_preset_reg;
  reg         bus_fault_flag_reg;
  reg         undervolt_reg;
  reg  [1:0]  bank_select_reg;
  reg  [3:0]  format_reg [0:7];
  reg  [7:0]  user_reg [0:15];

  reg  [15:0] resp_next;
  reg         resp_valid_next;
  reg  [3:0]  node_next;
  reg         bsw_next;
  reg         st_next;
  reg         prg_next;
  reg         bf_next;
  reg  [1:0]  bank_next;
  reg         fmt_we;
  reg         nvm_we;
  reg         uv_clear;

  wire        ground_loss_detect_enable           = device_config_two_reg[`DSRF_GROUND_LOSS_DETECT_ENABLE_BIT];
  wire        gf_seen        = GROUND_FAULT & ground_loss_detect_enable;
  wire        is_init        = (CMD_CODE == `DSRF_CMD_INIT) |
                               (CMD_CODE == `DSRF_CMD_REV_INIT);
  wire        addressed      = (CMD_ADDR == NODE_ADDRESS) &
                               (CMD_ADDR != `DSRF_GLOBAL_ADDR);
  wire        is_global      = (CMD_ADDR == `DSRF_GLOBAL_ADDR);
  wire        taken          = CMD_VALID & CMD_CRC_OK;
  wire [3:0]  assigned_address = CMD_DATA[3:0];
  wire [1:0]  bank_cmd       = CMD_DATA[5:4];
  wire [2:0]  format_reg_select = CMD_DATA[6:4];
  wire [3:0]  user_reg_address  = CMD_DATA[7:4];
  wire        uv_now         = undervolt_reg | HOLD_CAPACITOR_LOW;

  // ****************************************
  // helper functions
  // ****************************************
  // the attribute code, the bank nibble and the status word are each called
  // from a single place, kept as functions rather than inline logic.
  // a status-type word is built the same way for status, self-test on and
  // self-test off; only the self-test state differs, in its own bit and the summary bit, and both always report the
  // state that the command leaves behind, not the state before it.

  // attribute code from lock and config one
  function [1:0] attr_code;
    input       lock;
    input [1:0] cfg;
    begin
      attr_code = lock ? cfg : 2'h2;
    end
  endfunction

  // nibble of a user register picked by the low bit of the bank select pair
  function [3:0] bank_nibble;
    input [7:0] data;
    input [1:0] bank;
    begin
      bank_nibble = bank[0] ? data[7:4] : data[3:0];
    end
  endfunction

  // status-type word shared by status and both self-test commands
  function [15:0] status_word;
    input [3:0] node;
    input       prg;
    input       uv;
    input       st;
    input       bsw;
    input [1:0] attr;
    input       s;
    input       gf;
    begin
      status_word = {node, 4'h0, prg, uv, st, bsw, attr, s, gf};
    end
  endfunction

  // ****************************************
  // command decode and response build
  // ****************************************
  // every flag is sampled here in one cycle so a response is a coherent snapshot
  // decode order matters: initialization is checked first because it is the
  // only command answered at address zero on a blank part; format control is
  // next because a global format write is acted on; all other commands need
  // an exact, non-global address match. anything not decoded stays silent,
  // which keeps reserved and unimplemented codes from answering.
  // limitation: only one command per cycle is decoded, so a command and its
  // answer never overlap with a second command in the same cycle.
  always @* begin
    resp_next       = RESP_WORD;
    resp_valid_next = 1'b0;
    node_next       = NODE_ADDRESS;
    bsw_next        = BUS_SWITCH_CLOSED;
    st_next         = SELFTEST_ACTIVE;
    prg_next        = OTP_PROGRAM_ENABLE;
    bf_next         = bus_fault_flag_reg;
    bank_next       = bank_select_reg;
    fmt_we          = 1'b0;
    nvm_we          = 1'b0;
    uv_clear        = 1'b0;
    if (taken & is_init) begin
      // preset part must be named by both fields; blank part takes zero command address
      if ((assigned_address != 4'h0) &
          (bank_cmd != `DSRF_BANK_INVALID) &
          (address_preset_reg ? ((CMD_ADDR == NODE_ADDRESS) &
                                 (assigned_address == NODE_ADDRESS))
                              : ((CMD_ADDR == 4'h0) &
                                 (NODE_ADDRESS == 4'h0)))) begin
        node_next       = assigned_address;
        bf_next         = BUS_TEST_FAULT;
        bsw_next        = CMD_DATA[`DSRF_BSW_BIT] & ~BUS_TEST_FAULT;
        prg_next        = CMD_DATA[`DSRF_PRG_BIT];
        bank_next       = bank_cmd;
        resp_valid_next = 1'b1;
        resp_next       = {assigned_address, 3'h0, BUS_TEST_FAULT,
                           CMD_DATA[`DSRF_PRG_BIT],
                           CMD_DATA[`DSRF_BSW_BIT] & ~BUS_TEST_FAULT,
                           bank_cmd, assigned_address};
      end
    end else if (taken & (CMD_CODE == `DSRF_CMD_FORMAT)) begin
      // a global write reaches every node at once, so nobody answers it
      if (CMD_DATA[`DSRF_FMT_RW_BIT] & (addressed | is_global))
        fmt_we = 1'b1;
      if (addressed) begin
        resp_valid_next = 1'b1;
        resp_next       = {NODE_ADDRESS, `DSRF_FMT_PATTERN, CMD_DATA[7:4],
                           CMD_DATA[`DSRF_FMT_RW_BIT] ? CMD_DATA[3:0]
                           : format_reg[format_reg_select]};
      end
    end else if (taken & addressed) begin
      case (CMD_CODE)
        `DSRF_CMD_STATUS, `DSRF_CMD_ST_OFF, `DSRF_CMD_ST_ON: begin
          if (CMD_CODE == `DSRF_CMD_ST_OFF)
            st_next = 1'b0;
          else if (CMD_CODE == `DSRF_CMD_ST_ON)
            st_next = 1'b1;
          resp_valid_next = 1'b1;
          resp_next = status_word(NODE_ADDRESS, OTP_PROGRAM_ENABLE, uv_now,
                                  st_next,
                                  BUS_SWITCH_CLOSED,
                                  attr_code(attribute_lock_reg,
                                            device_config_one_reg[1:0]),
                                  st_next | OTP_PARITY_FAULT |
                                  FUSE_THRESHOLD_FAULT | uv_now |
                                  gf_seen,
                                  gf_seen);
        end
        `DSRF_CMD_ACCEL: begin
          resp_valid_next = 1'b1;
          resp_next = {NODE_ADDRESS, gf_seen,
                       SELFTEST_ACTIVE | OTP_PARITY_FAULT |
                       FUSE_THRESHOLD_FAULT | uv_now | gf_seen,
                       ACCEL_RESULT};
        end
        `DSRF_CMD_REQ_ID: begin
          resp_valid_next = 1'b1;
          resp_next = {NODE_ADDRESS, 4'h0, VERSION_ID, `DSRF_ID_TAIL};
        end
        `DSRF_CMD_CLEAR: begin
          uv_clear = 1'b1;                                           // no answer by design
        end
        `DSRF_CMD_NVM: begin
          nvm_we          = OTP_PROGRAM_ENABLE;
          resp_valid_next = 1'b1;
          resp_next = {NODE_ADDRESS, user_reg_address, 2'h0, bank_select_reg,
                       OTP_PROGRAM_ENABLE ? CMD_DATA[3:0]
                       : bank_nibble(user_reg[user_reg_address],
                                     bank_select_reg)};
        end
        `DSRF_CMD_REG_READ: begin
          resp_valid_next = 1'b1;
          resp_next = {NODE_ADDRESS, CMD_DATA[3:0],
                       user_reg[CMD_DATA[3:0]]};
        end
        default: begin
          resp_valid_next = 1'b0;
        end
      endcase
    end
  end

  // ****************************************
  // control and response registers
  // ****************************************
  // the preset address is caught one edge after reset release, never under reset
  // a command arriving on that first edge gets no answer and no address change on purpose: the address
  // it would be compared with is not settled yet; its other effects, such as the switch and a global format write, still land.
  // the undervoltage flag is sticky so that a short dip between two polls is
  // still reported; only an addressed clear command lowers it again.
  always @(posedge CLOCK) begin
    if (!RST_N) begin
      NODE_ADDRESS       <= 4'h0;
      preset_pending_reg <= 1'b1;
      address_preset_reg <= 1'b0;
      RESP_VALID         <= 1'b0;
      RESP_WORD          <= 16'h0000;
      BUS_SWITCH_CLOSED  <= 1'b0;
      SELFTEST_ACTIVE    <= 1'b0;
      OTP_PROGRAM_ENABLE <= 1'b0;
      bus_fault_flag_reg <= 1'b0;
      bank_select_reg    <= 2'h0;
      undervolt_reg      <= 1'b0;
    end else begin
      preset_pending_reg <= 1'b0;
      if (preset_pending_reg) begin
        NODE_ADDRESS       <= PRESET_VALID ? PRESET_ADDR : 4'h0;
        address_preset_reg <= PRESET_VALID;
        RESP_VALID         <= 1'b0;
      end else begin
        NODE_ADDRESS <= node_next;
        RESP_VALID   <= resp_valid_next;
      end
      RESP_WORD          <= resp_next;
      BUS_SWITCH_CLOSED  <= bsw_next;
      SELFTEST_ACTIVE    <= st_next;
      OTP_PROGRAM_ENABLE <= prg_next;
      bus_fault_flag_reg <= bf_next;
      bank_select_reg    <= bank_next;
      // a dip in the same cycle as a clear still sets the flag
      undervolt_reg      <= HOLD_CAPACITOR_LOW | (undervolt_reg & ~uv_clear);
    end
  end

  // ****************************************
  // format and user storage
  // ****************************************
  // the nvm write stands in for otp programming; software may preload the array too
  // an nvm write and a software write in one cycle: the nvm write wins, since
  // it carries a command from the bus master that cannot be repeated cheaply.
  // format registers are written on addressed and global writes alike.
  integer i;
  always @(posedge CLOCK) begin
    if (!RST_N) begin
      for (i = 0; i < 8; i = i + 1)
        format_reg[i] <= `DSRF_FMT_RESET;
      for (i = 0; i < 16; i = i + 1)
        user_reg[i] <= `DSRF_USER_RESET;
    end else begin
      if (fmt_we)
        format_reg[format_reg_select] <= CMD_DATA[3:0];
      if (nvm_we) begin
        if (bank_select_reg[0])
          user_reg[user_reg_address][7:4] <= CMD_DATA[3:0];
        else
          user_reg[user_reg_address][3:0] <= CMD_DATA[3:0];
      end else if (REG_WR & (REG_ADDR[4] == 1'b1)) begin
        user_reg[REG_ADDR[3:0]] <= REG_WDATA;
      end
    end
  end

  // ****************************************
  // software register port
  // ****************************************
  // read data stand for exactly the cycle after the strobe
  // read data return to zero outside that cycle so a stale value is never
  // mistaken for a fresh one; unmapped addresses read as zero and writes to
  // them are dropped. the state word is read-only.
  always @(posedge CLOCK) begin
    if (!RST_N) begin
      device_config_one_reg <= `DSRF_CFG_RESET;
      device_config_two_reg <= `DSRF_CFG_RESET;
      attribute_lock_reg    <= 1'b0;
      REG_RDATA             <= 8'h00;
    end else begin
      if (REG_WR) begin
        case (REG_ADDR)
          `DSRF_REG_CFG_ONE: device_config_one_reg <= REG_WDATA;
          `DSRF_REG_CFG_TWO: device_config_two_reg <= REG_WDATA;
          `DSRF_REG_LOCK:    attribute_lock_reg    <= REG_WDATA[0];
          default:           attribute_lock_reg    <= attribute_lock_reg;
        endcase
      end
      if (REG_RD) begin
        if (REG_ADDR[4])
          REG_RDATA <= user_reg[REG_ADDR[3:0]];
        else begin
          case (REG_ADDR)
            `DSRF_REG_CFG_ONE: REG_RDATA <= device_config_one_reg;
            `DSRF_REG_CFG_TWO: REG_RDATA <= device_config_two_reg;
            `DSRF_REG_LOCK:    REG_RDATA <= {7'h00, attribute_lock_reg};
            `DSRF_REG_STATE:   REG_RDATA <= {bus_fault_flag_reg, undervolt_reg,
                                             OTP_PROGRAM_ENABLE, BUS_SWITCH_CLOSED,
                                             NODE_ADDRESS};
            default:           REG_RDATA <= 8'h00;
          endcase
        end
      end else begin
        REG_RDATA <= 8'h00;
      end
    end
  end

endmodule // dsrf_responder

// [verification/dsrf_responder_props.sv]
`timescale 1ns/10ps
`include "dsrf_consts.vh"
module dsrf_props (
  input wire        CLOCK,
  input wire        RST_N,
  input wire        CMD_VALID,
  input wire        CMD_CRC_OK,
  input wire [3:0]  CMD_CODE,
  input wire [7:0]  CMD_DATA,
  input wire [9:0]  ACCEL_RESULT,
  input wire        REG_RD,
  input wire [7:0]  REG_RDATA,
  input wire        RESP_VALID,
  input wire [15:0] RESP_WORD,
  input wire [3:0]  NODE_ADDRESS,
  input wire        BUS_SWITCH_CLOSED,
  input wire        SELFTEST_ACTIVE,
  input wire        OTP_PROGRAM_ENABLE
);
  // ****************************************
  // accepted command classes
  // ****************************************
  wire tk  = CMD_VALID && CMD_CRC_OK;
  wire ini = tk && (CMD_CODE == `DSRF_CMD_INIT || CMD_CODE == `DSRF_CMD_REV_INIT);
  wire sts = tk && CMD_CODE inside {`DSRF_CMD_STATUS, `DSRF_CMD_ST_OFF, `DSRF_CMD_ST_ON};
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RST_N);
  a_resp_cause: assert property (RESP_VALID |-> $past(tk))
    else $error("response without an accepted command");
  a_crc_drop: assert property (CMD_VALID && !CMD_CRC_OK |=> !RESP_VALID)
    else $error("response to a bad crc command");
  a_reserved_code: assert property (tk && CMD_CODE inside {4'h3, 4'h5, 4'h6, 4'h7, 4'h8,
    4'hE} |=> !RESP_VALID) else $error("response to a dead code");
  a_init_zero: assert property (ini && CMD_DATA[3:0] == 4'h0
    |=> !RESP_VALID && $stable(NODE_ADDRESS)) else $error("zero address assigned");
  a_bad_bank: assert property (ini && CMD_DATA[5:4] == `DSRF_BANK_INVALID |=> !RESP_VALID)
    else $error("response to invalid bank pair");
  a_init_echo: assert property (ini |=> !RESP_VALID || (RESP_WORD[3:0] == NODE_ADDRESS
    && RESP_WORD[15:12] == NODE_ADDRESS && RESP_WORD[11:9] == 3'h0)) else $error("init echo");
  a_fmt_pattern: assert property (tk && CMD_CODE == `DSRF_CMD_FORMAT
    |=> !RESP_VALID || RESP_WORD[11:8] == `DSRF_FMT_PATTERN) else $error("format pattern");
  a_accel_word: assert property (tk && CMD_CODE == `DSRF_CMD_ACCEL
    |=> !RESP_VALID || RESP_WORD[9:0] == $past(ACCEL_RESULT)) else $error("accel result");
  a_state_bits: assert property (sts |=> !RESP_VALID || (RESP_WORD[11:8] == 4'h0
    && RESP_WORD[7] == OTP_PROGRAM_ENABLE && RESP_WORD[5] == SELFTEST_ACTIVE
    && RESP_WORD[4] == BUS_SWITCH_CLOSED)) else $error("status bits differ from state");
  a_rdata_idle: assert property (!REG_RD |=> REG_RDATA == 8'h00)
    else $error("read data outside read cycle");
  c_init: cover property (ini ##1 RESP_VALID);
  c_fmt: cover property (tk && CMD_CODE == `DSRF_CMD_FORMAT ##1 RESP_VALID);
  c_stim: cover property (sts ##1 RESP_VALID && SELFTEST_ACTIVE);
endmodule // dsrf_props

bind dsrf_responder dsrf_props u_props (.*);

// [verification/dsrf_cmd_master.sv]
`timescale 1ns/10ps
// ****************************************
// bus master partner: one decoded long command per call
// ****************************************
module dsrf_cmd_master (
  input  wire       clk,
  output reg        cmd_valid,
  output reg        cmd_ok,
  output reg  [3:0] cmd_code,
  output reg  [3:0] cmd_addr,
  output reg  [7:0] cmd_data
);
  initial begin
    cmd_valid = 1'b0;
    cmd_ok    = 1'b0;
    cmd_code  = 4'h3;
    cmd_addr  = 4'h0;
    cmd_data  = 8'h00;
  end
  // fields stop meaning anything after the take edge, so show their inverse
  task issue(input [3:0] c, input [3:0] a, input [7:0] d, input ok);
    begin
      @(posedge clk);
      cmd_valid <= 1'b1;
      cmd_ok    <= ok;
      cmd_code  <= c;
      cmd_addr  <= a;
      cmd_data  <= d;
      @(posedge clk);
      cmd_valid <= 1'b0;
      cmd_ok    <= ~ok;
      cmd_code  <= ~c;
      cmd_addr  <= ~a;
      cmd_data  <= ~d;
    end
  endtask
endmodule // dsrf_cmd_master

// [verification/dsrf_responder_tb.sv]
`timescale 1ns/10ps
`include "dsrf_consts.vh"
module dsrf_responder_tb;
  reg         clk = 1'b0;
  reg         rst_n = 1'b0;
  reg  [3:0]  pre_a = 4'h0;
  reg         pre_v = 1'b0, btf = 1'b0, gnd = 1'b0, hcl = 1'b0, par = 1'b0, fus = 1'b0;
  reg  [9:0]  acc = 10'h000;
  reg  [4:0]  r_addr = 5'h00;
  reg  [7:0]  r_wd = 8'h00;
  reg         r_wr = 1'b0, r_rd = 1'b0;
  wire        cv, ck, rv, bsc, sta, ope;
  wire [3:0]  cc, ca, node;
  wire [7:0]  cd, rdata;
  wire [15:0] rw;
  integer     err_count = 0;
  integer     n_compared = 0;
  integer     i;
  reg         nv = 1'b0, u = 1'b0, st = 1'b0, lk = 1'b0, gl = 1'b0, bs = 1'b0;
  reg  [1:0]  cfg;
  reg  [7:0]  got8, rb;
  reg  [3:0]  fmt [0:7];
  always #5 clk = ~clk;
  dsrf_cmd_master u_mst (.clk(clk), .cmd_valid(cv), .cmd_ok(ck), .cmd_code(cc),
    .cmd_addr(ca), .cmd_data(cd));
  dsrf_responder u_dut (.CLOCK(clk), .RST_N(rst_n), .CMD_VALID(cv), .CMD_CRC_OK(ck),
    .CMD_CODE(cc), .CMD_ADDR(ca), .CMD_DATA(cd), .PRESET_ADDR(pre_a), .PRESET_VALID(pre_v),
    .BUS_TEST_FAULT(btf), .GROUND_FAULT(gnd), .HOLD_CAPACITOR_LOW(hcl),
    .OTP_PARITY_FAULT(par), .FUSE_THRESHOLD_FAULT(fus), .ACCEL_RESULT(acc),
    .REG_ADDR(r_addr), .REG_WDATA(r_wd), .REG_WR(r_wr), .REG_RD(r_rd), .REG_RDATA(rdata),
    .RESP_VALID(rv), .RESP_WORD(rw), .NODE_ADDRESS(node), .BUS_SWITCH_CLOSED(bsc),
    .SELFTEST_ACTIVE(sta), .OTP_PROGRAM_ENABLE(ope));
  // ****************************************
  // expectations and bus tasks
  // ****************************************
  function sbit(input dummy);
    sbit = st | par | fus | u | (gnd & gl);
  endfunction
  function [15:0] stw(input [3:0] n);
    stw = {n, 4'h0, nv, u, st, bs, (lk ? cfg : 2'h2), sbit(1'b0), gnd & gl};
  endfunction
  task chk(input [15:0] g, input [15:0] e);
    begin
      n_compared = n_compared + 1;
      if (g !== e) begin
        err_count = err_count + 1;
        $display("mismatch at %0t: got %h expected %h", $time, g, e);
      end
    end
  endtask
  // response is sampled 1 ns after the take edge, while it stands
  task send(input [3:0] c, input [3:0] a, input [7:0] d, input ok, input ev, input [15:0] ew);
    begin
      u_mst.issue(c, a, d, ok);
      #1;
      chk({15'h0, rv}, {15'h0, ev});
      if (ev) chk(rw, ew);
    end
  endtask
  task wr(input [4:0] a, input [7:0] d);
    begin
      @(posedge clk);
      r_wr <= 1'b1;
      r_addr <= a;
      r_wd <= d;
      @(posedge clk);
      r_wr <= 1'b0;
    end
  endtask
  task rd(input [4:0] a);
    begin
      @(posedge clk);
      r_rd <= 1'b1;
      r_addr <= a;
      @(posedge clk);
      r_rd <= 1'b0;
      #1 got8 = rdata;
    end
  endtask
  task wrap_up;
    begin
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask
  // watchdog: the sequence needs well under a thousand cycles
  initial begin
    #100000;
    err_count = err_count + 1;
    wrap_up;
  end
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    rb = $urandom(32'h1004238c);
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1 chk({node, bsc, ope}, 6'h00);
    send(`DSRF_CMD_INIT, 4'h0, 8'h50, 1'b1, 1'b0, 16'h0);
    send(`DSRF_CMD_INIT, 4'h0, 8'h35, 1'b1, 1'b0, 16'h0);
    send(`DSRF_CMD_INIT, 4'h0, 8'hD5, 1'b1, 1'b1, 16'h50D5);
    chk({bsc, ope, node}, 6'h35);
    nv = 1'b1;
    bs = 1'b1;
    send(`DSRF_CMD_INIT, 4'h5, 8'h17, 1'b1, 1'b0, 16'h0);
    $display("test init done");
    send(`DSRF_CMD_STATUS, 4'h5, 8'h00, 1'b1, 1'b1, stw(4'h5));
    wr(`DSRF_REG_LOCK, 8'h01);
    lk = 1'b1;
    for (i = 0; i < 4; i = i + 1) begin
      cfg = i;
      rb = $urandom;
      wr(`DSRF_REG_CFG_ONE, {rb[7:2], cfg});
      send(`DSRF_CMD_STATUS, 4'h5, rb, 1'b1, 1'b1, stw(4'h5));
    end
    for (i = 0; i < 6; i = i + 1) begin
      rb = $urandom;
      gl = (i == 0) ? 1'b1 : (i == 1) ? 1'b0 : rb[1];
      @(posedge clk);
      gnd <= (i < 2) | rb[0];
      par <= rb[2] & (i > 1);
      fus <= rb[3] & (i > 2);
      acc <= $urandom;
      wr(`DSRF_REG_CFG_TWO, {7'h0, gl});
      send(`DSRF_CMD_ACCEL, 4'h5, rb, 1'b1, 1'b1, {4'h5, gnd & gl, sbit(1'b0), acc});
      send(`DSRF_CMD_STATUS, 4'h5, rb, 1'b1, 1'b1, stw(4'h5));
    end
    @(posedge clk);
    gnd <= 1'b0;
    par <= 1'b0;
    fus <= 1'b0;
    hcl <= 1'b1;
    @(posedge clk);
    hcl <= 1'b0;
    u = 1'b1;
    send(`DSRF_CMD_STATUS, 4'h5, 8'h00, 1'b1, 1'b1, stw(4'h5));
    send(`DSRF_CMD_CLEAR, 4'h5, 8'h00, 1'b1, 1'b0, 16'h0);
    u = 1'b0;
    st = 1'b1;
    send(`DSRF_CMD_ST_ON, 4'h5, 8'h00, 1'b1, 1'b1, stw(4'h5));
    st = 1'b0;
    send(`DSRF_CMD_ST_OFF, 4'h5, 8'h00, 1'b1, 1'b1, stw(4'h5));
    $display("test status done");
    for (i = 0; i < 8; i = i + 1) begin
      rb = $urandom;
      fmt[i] = rb[3:0];
      send(`DSRF_CMD_FORMAT, 4'h5, {1'b1, i[2:0], rb[3:0]}, 1'b1, 1'b1,
        {4'h5, 4'h6, 1'b1, i[2:0], rb[3:0]});
    end
    send(`DSRF_CMD_FORMAT, 4'h0, 8'hAC, 1'b1, 1'b0, 16'h0);
    fmt[2] = 4'hC;
    for (i = 0; i < 8; i = i + 1)
      send(`DSRF_CMD_FORMAT, 4'h5, {1'b0, i[2:0], 4'h9}, 1'b1, 1'b1,
        {4'h5, 4'h6, 1'b0, i[2:0], fmt[i]});
    for (i = 0; i < 4; i = i + 1) begin
      rb = $urandom;
      cfg = $urandom;
      wr(`DSRF_REG_USER_BASE | {1'b0, rb[3:0]}, {cfg, rb[7:2]});
      send(`DSRF_CMD_REG_READ, 4'h5, {4'h0, rb[3:0]}, 1'b1, 1'b1,
        {4'h5, rb[3:0], cfg, rb[7:2]});
    end
    wr(5'h13, 8'h00);
    send(`DSRF_CMD_NVM, 4'h5, 8'h3A, 1'b1, 1'b1, 16'h531A);
    send(`DSRF_CMD_REG_READ, 4'h5, 8'h03, 1'b1, 1'b1, 16'h53A0);
    send(`DSRF_CMD_REQ_ID, 4'h5, 8'h00, 1'b1, 1'b1, 16'h5024);
    rd(`DSRF_REG_STATE);
    chk(got8, 8'h35);
    rd(5'h05);
    chk(got8, 8'h00);
    for (i = 0; i < 5; i = i + 1)
      send(i == 0 ? 4'h3 : i == 1 ? 4'h5 : i == 2 ? 4'h6 : i == 3 ? 4'h8 : 4'hE,
        4'h5, 8'h00, 1'b1, 1'b0, 16'h0);
    send(`DSRF_CMD_STATUS, 4'h5, 8'h00, 1'b0, 1'b0, 16'h0);
    $display("test format and register done");
    @(posedge clk);
    pre_v <= 1'b1;
    pre_a <= 4'h9;
    btf <= 1'b1;
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1 chk({node, bsc, ope, sta}, 7'h48);
    send(`DSRF_CMD_REV_INIT, 4'h9, 8'h59, 1'b1, 1'b1, 16'h9119);
    chk({15'h0, bsc}, 16'h0);
    $display("test preset and bus fault done");
    wrap_up;
  end
endmodule // dsrf_responder_tb
